// ---- core/dac_pkg.sv ----
package dac_pkg;

    // Serial address: four fixed bits above three strap bits
    localparam int            ADDR_W      = 7;
    localparam logic [3:0]    ADDR_HI_STD = 4'h4;
    localparam logic [3:0]    ADDR_HI_ALT = 4'h3;
    localparam logic [6:0]    SYNC_ADDR   = 7'h7E;

    // Byte framing
    localparam logic [2:0]    BIT_LAST    = 3'h7;
    localparam logic [2:0]    BIT_FIRST   = 3'h0;
    localparam logic [2:0]    BIT_STEP    = 3'h1;
    localparam logic [7:0]    BYTE_ZERO   = 8'h00;

    // Command byte fields
    localparam int            CMD_SYNC_SEL = 0;
    localparam int            CMD_PWR_DOWN = 1;
    localparam int            CMD_REF_SEL  = 2;

    // Converter code
    localparam int            DAC_W       = 10;
    localparam int            MSB_BITS    = 2;

    // Synchroniser lanes
    localparam int            LANE_SDA    = 0;
    localparam int            LANE_SCL    = 1;
    localparam int            LANE_BIT    = 2;
    localparam int            LANE_STRAP0 = 3;
    localparam int            LANE_STRAP1 = 4;
    localparam int            LANE_STRAP2 = 5;
    localparam int            SYNC_W      = 6;
    localparam logic [5:0]    SYNC_RST    = 6'h3F;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_RX     = 2'h1,
        ST_ACK    = 2'h2,
        ST_IGNORE = 2'h3
    } link_state_e;

    typedef enum logic [1:0] {
        PH_ADDR = 2'h0,
        PH_CMD  = 2'h1,
        PH_LSB  = 2'h2,
        PH_MSB  = 2'h3
    } byte_phase_e;

endpackage

// ---- core/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst_b,
    // Lanes to synchronise
    pin_sync_if.syncer  ps
);
    typedef struct packed {
        logic [dac_pkg::SYNC_W-1:0] s1;
        logic [dac_pkg::SYNC_W-1:0] s2;
    } sync_s;

    sync_s q;
    sync_s d;

    // First stage feeds only the second stage
    always_comb begin
        d    = q;
        d.s1 = ps.raw;
        d.s2 = q.s1;
    end

    // Idle bus is high, so reset to ones avoids a false start
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= {dac_pkg::SYNC_RST, dac_pkg::SYNC_RST};
        end else begin
            q <= d;
        end
    end

    assign ps.sync = q.s2;
endmodule

// ---- core/pin_sync_if.sv ----
`timescale 1ns/100ps
interface pin_sync_if;
    logic [dac_pkg::SYNC_W-1:0] raw;
    logic [dac_pkg::SYNC_W-1:0] sync;
    modport user   (output raw, input sync);
    modport syncer (input raw, output sync);
endinterface

// ---- core/scl_bit_capture.sv ----
`timescale 1ns/100ps
module scl_bit_capture (
    // Link clock and data
    input  wire logic scl,
    input  wire logic sda_in,
    // Captured bit
    output logic      bit_q
);
    typedef struct packed {
        logic bit_v;
    } cap_s;

    cap_s q;
    cap_s d;

    always_comb begin
        d       = q;
        d.bit_v = sda_in;
    end

    // Clock stands still between frames, so no reset here; the bit is
    // only read after a rising edge has been seen in the system domain
    // sample on rising edge
    always_ff @(posedge scl) begin
        q <= d;
    end

    assign bit_q = q.bit_v;
endmodule

// ---- core/smbus_dac_write_receiver.sv ----
`timescale 1ns/100ps
module smbus_dac_write_receiver #(
    parameter bit ALT_VARIANT = 1'b0
) (
    // System clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Serial bus
    input  wire logic                        scl,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    // Address straps
    input  wire logic                        addr_select_bit0,
    input  wire logic                        addr_select_bit1,
    input  wire logic                        addr_select_bit2,
    // Converter controls
    output logic [dac_pkg::DAC_W-1:0]        dac_code,
    output logic                             power_down,
    output logic                             reference_select,
    output logic                             sync_update_select
);
    typedef struct packed {
        dac_pkg::link_state_e st;
        dac_pkg::byte_phase_e phase;
        logic [2:0]           cnt;
        logic [7:0]           shift;
        logic                 ack_pend;
        logic                 sync_adr;
        logic                 quick_bit;
        logic                 sda_oe;
        logic                 scl_p;
        logic                 sda_p;
        logic                 sample;
        logic [7:0]           cmd;
        logic [7:0]           lsb_in;
        logic [7:0]           lsb_keep;
        logic [7:0]           msb_in;
        logic [dac_pkg::DAC_W-1:0] dac;
        logic                 pd;
    } rx_s;

    rx_s q;
    rx_s d;

    pin_sync_if ps ();

    logic                      bit_q;
    logic                      scl_s;
    logic                      sda_s;
    logic                      bit_s;
    logic [6:0]                own_addr;
    logic [7:0]                byte_w;
    logic                      start_w;
    logic                      stop_w;
    logic                      rise_w;
    logic                      fall_w;
    logic                      last_w;
    logic                      clear_w;
    logic                      sync_upd_w;
    logic [dac_pkg::DAC_W-1:0] upd_code;

    // code from high bits over low byte
    function automatic logic [dac_pkg::DAC_W-1:0] code_of(
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        code_of = {hi[dac_pkg::MSB_BITS-1:0], lo};
    endfunction

    function automatic dac_pkg::byte_phase_e next_phase(input dac_pkg::byte_phase_e p);
        case (p)
            dac_pkg::PH_ADDR: next_phase = dac_pkg::PH_CMD;
            dac_pkg::PH_CMD:  next_phase = dac_pkg::PH_LSB;
            default:          next_phase = dac_pkg::PH_MSB;
        endcase
    endfunction

    scl_bit_capture u_cap (
        .scl    (scl),
        .sda_in (sda_in),
        .bit_q  (bit_q)
    );

    pin_sync u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .ps    (ps)
    );

    assign ps.raw = {addr_select_bit2, addr_select_bit1, addr_select_bit0,
                     bit_q, scl, sda_in};
    assign scl_s  = ps.sync[dac_pkg::LANE_SCL];
    assign sda_s  = ps.sync[dac_pkg::LANE_SDA];
    assign bit_s  = ps.sync[dac_pkg::LANE_BIT];

    // straps form low bits, bit 2 first
    assign own_addr = {ALT_VARIANT ? dac_pkg::ADDR_HI_ALT : dac_pkg::ADDR_HI_STD,
                       ps.sync[dac_pkg::LANE_STRAP2], ps.sync[dac_pkg::LANE_STRAP1],
                       ps.sync[dac_pkg::LANE_STRAP0]};

    // start: data falls while clock high
    assign start_w = scl_s && q.scl_p && q.sda_p && !sda_s;
    // stop: data rises while clock high
    assign stop_w  = scl_s && q.scl_p && !q.sda_p && sda_s;
    assign rise_w  = scl_s && !q.scl_p;
    assign fall_w  = !scl_s && q.scl_p;
    assign byte_w  = {q.shift[6:0], bit_s};
    assign last_w  = q.cnt == dac_pkg::BIT_LAST;
    assign upd_code = code_of(q.msb_in, q.lsb_keep);

    // Sync quick command acts on the acknowledge rising edge
    assign clear_w    = q.st == dac_pkg::ST_ACK && q.sample && q.sync_adr && !q.quick_bit;
    assign sync_upd_w = q.st == dac_pkg::ST_ACK && q.sample && q.sync_adr && q.quick_bit;

    always_comb begin
        d        = q;
        d.scl_p  = scl_s;
        d.sda_p  = sda_s;
        // Bit lane may lag the clock lane by one cycle, so sample late
        d.sample = rise_w;
        if (start_w || stop_w) begin
            d.lsb_in   = q.lsb_keep;
            d.sda_oe   = 1'b0;
            d.ack_pend = 1'b0;
            d.sync_adr = 1'b0;
            d.cnt      = dac_pkg::BIT_FIRST;
            d.phase    = dac_pkg::PH_ADDR;
            if (stop_w) begin
                d.st = dac_pkg::ST_IDLE;
                if (!q.cmd[dac_pkg::CMD_SYNC_SEL]) begin
                    d.dac = upd_code;
                end
                d.pd = q.cmd[dac_pkg::CMD_PWR_DOWN];
            end else begin
                d.st = dac_pkg::ST_RX;
            end
        end else begin
            case (q.st)
                dac_pkg::ST_RX: begin
                    if (q.sample) begin
                        d.shift = byte_w;
                        d.cnt   = 3'(q.cnt + dac_pkg::BIT_STEP);
                        if (last_w) begin
                            if (q.phase == dac_pkg::PH_ADDR) begin
                                // own address only with write bit
                                if (byte_w[7:1] == own_addr && !byte_w[0]) begin
                                    d.ack_pend = 1'b1;
                                // shared address, last bit is mode
                                end else if (byte_w[7:1] == dac_pkg::SYNC_ADDR) begin
                                    d.ack_pend = 1'b1;
                                    d.sync_adr = 1'b1;
                                    d.quick_bit = byte_w[0];
                                end else begin
                                    // not ours: stay off the bus
                                    d.st = dac_pkg::ST_IGNORE;
                                end
                            end else begin
                                d.ack_pend = 1'b1;
                            end
                        end
                    end
                    // pull low from the falling edge
                    if (fall_w && q.ack_pend) begin
                        d.ack_pend = 1'b0;
                        d.sda_oe   = 1'b1;
                        d.st       = dac_pkg::ST_ACK;
                    end
                end
                dac_pkg::ST_ACK: begin
                    if (q.sample) begin
                        case (q.phase)
                            dac_pkg::PH_ADDR: begin
                                if (clear_w) begin
                                    d.cmd      = dac_pkg::BYTE_ZERO;
                                    d.lsb_in   = dac_pkg::BYTE_ZERO;
                                    d.lsb_keep = dac_pkg::BYTE_ZERO;
                                    d.msb_in   = dac_pkg::BYTE_ZERO;
                                    d.dac      = '0;
                                    d.pd       = 1'b0;
                                end else if (sync_upd_w && q.cmd[dac_pkg::CMD_SYNC_SEL]) begin
                                    d.dac = upd_code;
                                end
                            end
                            dac_pkg::PH_CMD: d.cmd = q.shift;
                            dac_pkg::PH_LSB: d.lsb_in = q.shift;
                            default: begin
                                d.msb_in   = q.shift;
                                d.lsb_keep = q.lsb_in;
                            end
                        endcase
                    end
                    if (fall_w) begin
                        d.sda_oe = 1'b0;
                        d.cnt    = dac_pkg::BIT_FIRST;
                        if (q.phase == dac_pkg::PH_MSB || q.sync_adr) begin
                            d.st = dac_pkg::ST_IGNORE;
                        end else begin
                            d.phase = next_phase(q.phase);
                            d.st    = dac_pkg::ST_RX;
                        end
                    end
                end
                // idle and ignore leave the line released
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // Edge history starts at the idle high level, so no false edge
            q       <= '0;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Open drain: only ever drives low
    assign sda_out            = 1'b0;
    assign sda_oe             = q.sda_oe;
    assign dac_code           = q.dac;
    assign power_down         = q.pd;
    assign reference_select   = q.cmd[dac_pkg::CMD_REF_SEL];
    assign sync_update_select = q.cmd[dac_pkg::CMD_SYNC_SEL];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic quiet_w;
    assign quiet_w = !start_w && !stop_w;

    a_oe_only_ack: assert property (
        q.sda_oe |-> q.st == dac_pkg::ST_ACK
    ) else $error("data pin driven outside acknowledge");

    a_rise_sampled: assert property (
        $rose(scl_s) |=> q.sample ##1 !q.sample
    ) else $error("clock rise not sampled once");

    a_own_addr_ack: assert property (
        (q.st == dac_pkg::ST_RX && q.phase == dac_pkg::PH_ADDR && q.sample && last_w
         && quiet_w && byte_w == {own_addr, 1'b0}) |=> q.ack_pend
    ) else $error("own address not acknowledged");

    a_read_refused: assert property (
        (q.st == dac_pkg::ST_RX && q.phase == dac_pkg::PH_ADDR && q.sample && last_w
         && quiet_w && byte_w == {own_addr, 1'b1}) |=> q.st == dac_pkg::ST_IGNORE
    ) else $error("read request accepted");

    a_foreign_ignored: assert property (
        (q.st == dac_pkg::ST_RX && q.phase == dac_pkg::PH_ADDR && q.sample && last_w
         && quiet_w && byte_w[7:1] != own_addr && byte_w[7:1] != dac_pkg::SYNC_ADDR)
        |=> q.st == dac_pkg::ST_IGNORE && !q.sda_oe
    ) else $error("foreign address not ignored");

    a_start_frames: assert property (
        start_w |=> q.st == dac_pkg::ST_RX && q.cnt == dac_pkg::BIT_FIRST
                    && q.phase == dac_pkg::PH_ADDR && !q.sda_oe
    ) else $error("start not framed");

    a_stop_idles: assert property (
        stop_w |=> q.st == dac_pkg::ST_IDLE ##1 (q.st == dac_pkg::ST_IDLE || start_w)
    ) else $error("stop did not idle");

    a_ack_begins: assert property (
        (q.st == dac_pkg::ST_RX && q.ack_pend && fall_w && quiet_w) |=> q.sda_oe
    ) else $error("acknowledge not driven");

    a_ack_holds: assert property (
        (q.sda_oe && scl_s && quiet_w) |=> q.sda_oe
    ) else $error("acknowledge released while clock high");

    a_cmd_latched: assert property (
        (q.st == dac_pkg::ST_ACK && q.sample && q.phase == dac_pkg::PH_CMD && quiet_w)
        |=> q.cmd == $past(q.shift)
    ) else $error("command not latched");

    a_word_latched: assert property (
        (q.st == dac_pkg::ST_ACK && q.sample && q.phase == dac_pkg::PH_MSB && quiet_w)
        |=> q.msb_in == $past(q.shift) && q.lsb_keep == $past(q.lsb_in)
    ) else $error("data word not latched");

    a_stop_update: assert property (
        (stop_w && !q.cmd[dac_pkg::CMD_SYNC_SEL]) |=> dac_code == $past(upd_code)
    ) else $error("stop did not update code");

    a_sync_holds: assert property (
        (stop_w && q.cmd[dac_pkg::CMD_SYNC_SEL]) |=> $stable(dac_code)
    ) else $error("sync mode updated on stop");

    a_pd_at_stop: assert property (
        $changed(power_down) |-> $past(stop_w) || $past(clear_w)
    ) else $error("power-down changed off stop");

    a_data_reverts: assert property (
        (start_w || stop_w) |=> q.lsb_in == $past(q.lsb_keep) && $stable(q.cmd)
    ) else $error("interrupted word not discarded");

    a_sync_clear: assert property (
        (clear_w && quiet_w) |=> dac_code == '0 && q.cmd == dac_pkg::BYTE_ZERO && !power_down
    ) else $error("shared clear failed");

    c_word_done: cover property (
        q.st == dac_pkg::ST_ACK && q.sample && q.phase == dac_pkg::PH_MSB ##[1:1000] stop_w
    );
    c_sync_update: cover property (sync_upd_w && q.cmd[dac_pkg::CMD_SYNC_SEL]);
    c_sync_clear: cover property (clear_w);
    c_foreign: cover property (q.st == dac_pkg::ST_IGNORE && q.phase == dac_pkg::PH_ADDR);
endmodule

// ---- verification/smbus_host_model.sv ----
`timescale 1ns/100ps
module smbus_host_model (
    // Link time base
    input  wire logic lclk,
    input  wire logic slow,
    // Bus wires
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
    endtask

    // Slow mode stretches the high phase like a sluggish host
    task automatic pulse(output logic s1, output logic s2);
        scl = 1'b1;
        tick(1);
        s1 = sda_w;
        tick(slow ? 9 : 3);
        s2 = sda_w;
        scl = 1'b0;
        tick(3);
    endtask

    task automatic start_cond();
        sda_low = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(3);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(6);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack, output logic clash);
        logic s1;
        logic s2;
        clash = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sda_low = ~b[i];
            tick(3);
            pulse(s1, s2);
            if (s1 !== b[i] || s2 !== b[i]) begin
                clash = 1'b1;
            end
        end
        sda_low = 1'b0;
        tick(3);
        pulse(s1, s2);
        ack = (s1 === 1'b0) && (s2 === 1'b0);
    endtask
endmodule

// ---- verification/test_smbus_dac_write_receiver.sv ----
`timescale 1ns/100ps
module test_smbus_dac_write_receiver;
    typedef struct packed {
        logic [2:0] strap;
        logic [7:0] cmd;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [9:0] code;
    } row_s;

    logic        clk;
    logic        lclk;
    logic        rst_b;
    logic        slow;
    logic        scl;
    logic        sda_low;
    logic        sda_w;
    logic        sda_out;
    logic        sda_oe;
    logic [2:0]  strap;
    logic [9:0]  dac_code;
    logic        power_down;
    logic        reference_select;
    logic        sync_update_select;
    logic        ack;
    logic        clash;
    logic        alt_oe;
    logic        alt_seen;
    int          n_mismatch;
    int          cmp_count;
    row_s        rows [8];

    // Open-drain wire with pull-up
    assign sda_w = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    smbus_dac_write_receiver uut (
        .clk                (clk),
        .rst_b              (rst_b),
        .scl                (scl),
        .sda_in             (sda_w),
        .sda_out            (sda_out),
        .sda_oe             (sda_oe),
        .addr_select_bit0   (strap[0]),
        .addr_select_bit1   (strap[1]),
        .addr_select_bit2   (strap[2]),
        .dac_code           (dac_code),
        .power_down         (power_down),
        .reference_select   (reference_select),
        .sync_update_select (sync_update_select)
    );

    // Other variant on the same wires; its acknowledge is watched, not
    // wired, so the main target's refusals stay visible to the host
    smbus_dac_write_receiver #(
        .ALT_VARIANT (1'b1)
    ) uut_alt (
        .clk                (clk),
        .rst_b              (rst_b),
        .scl                (scl),
        .sda_in             (sda_w),
        .sda_out            (),
        .sda_oe             (alt_oe),
        .addr_select_bit0   (strap[0]),
        .addr_select_bit1   (strap[1]),
        .addr_select_bit2   (strap[2]),
        .dac_code           (),
        .power_down         (),
        .reference_select   (),
        .sync_update_select ()
    );

    // Sticky record of any acknowledge from the other variant
    always @(posedge clk) begin
        if (!rst_b) begin
            alt_seen <= 1'b0;
        end else if (alt_oe) begin
            alt_seen <= 1'b1;
        end
    end

    smbus_host_model host (
        .lclk    (lclk),
        .slow    (slow),
        .sda_w   (sda_w),
        .scl     (scl),
        .sda_low (sda_low)
    );

    always #5 clk = ~clk;

    // Link time base, offset so its edges fall between clk edges
    initial begin
        lclk = 1'b0;
        #7.3;
        forever #15 lclk = ~lclk;
    end

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic put(input logic [7:0] b, input logic exp_ack);
        host.send_byte(b, ack, clash);
        check({11'h000, ack, clash}, {11'h000, exp_ack, 1'b0});
    endtask

    task automatic status(input logic [9:0] code, input logic [2:0] ctl, input string name);
        @(negedge clk);
        check({dac_code, power_down, reference_select, sync_update_select}, {code, ctl});
        check({11'h000, sda_oe, sda_out}, 13'h0000);
        $display("Test %s done", name);
    endtask

    task automatic word(input logic [7:0] cmd, input logic [7:0] lo, input logic [7:0] hi);
        host.start_cond();
        put({dac_pkg::ADDR_HI_STD, strap, 1'b0}, 1'b1);
        put(cmd, 1'b1);
        put(lo, 1'b1);
        put(hi, 1'b1);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        $display("Error at %0t: run timed out", $time);
        conclude();
    end

    initial begin
        clk        = 1'b0;
        rst_b      = 1'b0;
        slow       = 1'b0;
        strap      = 3'h0;
        n_mismatch = 0;
        cmp_count  = 0;
        rows[0] = {3'h0, 8'h00, 8'h5A, 8'hFE, 10'h25A};
        rows[1] = {3'h1, 8'h04, 8'hFF, 8'h03, 10'h3FF};
        rows[2] = {3'h2, 8'hF8, 8'h01, 8'hFC, 10'h001};
        rows[3] = {3'h3, 8'h06, 8'h80, 8'h01, 10'h180};
        rows[4] = {3'h4, 8'h00, 8'h00, 8'h00, 10'h000};
        rows[5] = {3'h5, 8'h02, 8'hA5, 8'h02, 10'h2A5};
        rows[6] = {3'h6, 8'h04, 8'h3C, 8'hFD, 10'h13C};
        rows[7] = {3'h7, 8'hFA, 8'hC3, 8'h00, 10'h0C3};
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        // Each row uses its own straps
        foreach (rows[i]) begin
            @(negedge clk);
            strap = rows[i].strap;
            repeat (4) @(negedge clk);
            word(rows[i].cmd, rows[i].lo, rows[i].hi);
            host.stop_cond();
            status(rows[i].code, {rows[i].cmd[1], rows[i].cmd[2], rows[i].cmd[0]}, "row");
        end
        // Foreign nibble, wrong straps and a read are all refused
        check({12'h000, alt_seen}, 13'h0000);
        host.start_cond();
        put({dac_pkg::ADDR_HI_ALT, strap, 1'b0}, 1'b0);
        check({12'h000, alt_seen}, 13'h0001);
        put(8'h00, 1'b0);
        host.start_cond();
        put({dac_pkg::ADDR_HI_STD, 3'h3, 1'b0}, 1'b0);
        host.start_cond();
        put({dac_pkg::ADDR_HI_STD, strap, 1'b1}, 1'b0);
        host.stop_cond();
        status(10'h0C3, 3'h4, "refusals");
        // Word cut after the low byte, host running slow
        slow = 1'b1;
        host.start_cond();
        put({dac_pkg::ADDR_HI_STD, strap, 1'b0}, 1'b1);
        put(8'h04, 1'b1);
        put(8'h11, 1'b1);
        host.stop_cond();
        status(10'h0C3, 3'h2, "interrupted");
        slow = 1'b0;
        // Send byte with power-down
        host.start_cond();
        put({dac_pkg::ADDR_HI_STD, strap, 1'b0}, 1'b1);
        put(8'h02, 1'b1);
        host.stop_cond();
        status(10'h0C3, 3'h4, "send_byte");
        // Sync mode holds the output until the shared update
        word(8'h01, 8'h77, 8'h01);
        host.stop_cond();
        status(10'h0C3, 3'h1, "sync_hold");
        word(8'h01, 8'h22, 8'h02);
        host.start_cond();
        put({dac_pkg::SYNC_ADDR, 1'b1}, 1'b1);
        status(10'h222, 3'h1, "sync_update");
        host.stop_cond();
        host.start_cond();
        put({dac_pkg::SYNC_ADDR, 1'b0}, 1'b1);
        host.stop_cond();
        status(10'h000, 3'h0, "shared_clear");
        // Quick command to own address
        host.start_cond();
        put({dac_pkg::ADDR_HI_STD, strap, 1'b0}, 1'b1);
        host.stop_cond();
        status(10'h000, 3'h0, "quick");
        // Reset in mid-run clears everything
        word(8'h06, 8'hFF, 8'h03);
        host.stop_cond();
        status(10'h3FF, 3'h6, "before_reset");
        rst_b = 1'b0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        status(10'h000, 3'h0, "reset");
        conclude();
    end
endmodule
